// ### sfps_fuse_bank.sv
`timescale 1ns/1ps
// Per-page burned flags and pointer snapshot taken at reset release
module sfps_fuse_bank (
    input wire logic CLK,
    input wire logic RST,
    input wire logic burn,
    input wire logic [3:0] page_idx,
    input wire logic [7:0] ptr_live,
    output logic [7:0] burned,
    output logic [7:0] ptr_applied
);
    logic snap_done_r;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            burned <= sfps_pkg::RST_BYTE;
        end else if (burn) begin
            burned[page_idx[2:0]] <= 1'b1;
        end
    end

    // Pointer captured once after reset release, then frozen until next reset
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            snap_done_r <= 1'b0;
            ptr_applied <= sfps_pkg::RST_BYTE;
        end else if (!snap_done_r) begin
            snap_done_r <= 1'b1;
            ptr_applied <= ptr_live;
        end
    end
endmodule

// ### sfps_host_model.sv
`timescale 1ns/1ps
module sfps_host_model (
    input wire logic CLK,
    input wire logic [7:0] RDATA,
    output logic WR_EN,
    output logic RD_EN,
    output logic [7:0] ADDR,
    output logic [7:0] WDATA
);
    logic [7:0] rd_val;
    initial begin
        WR_EN = 1'b0;
        RD_EN = 1'b0;
        ADDR = 8'h00;
        WDATA = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLK);
        WR_EN = 1'b1;
        ADDR = a;
        WDATA = d;
        @(negedge CLK);
        WR_EN = 1'b0;
        // Released bus carries no stale value
        ADDR = ~a;
        WDATA = ~d;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge CLK);
        RD_EN = 1'b1;
        ADDR = a;
        @(posedge CLK);
        rd_val = RDATA;
        @(negedge CLK);
        RD_EN = 1'b0;
        ADDR = ~a;
    endtask
    task automatic pulse_cmd(input logic [7:0] c);
        wr(8'h0F, 8'h00);
        wr(8'h0F, c);
        wr(8'h0F, 8'h00);
    endtask
    task automatic set_bit(input logic [7:0] a, input int b);
        rd(a);
        wr(a, rd_val | (8'h01 << b));
    endtask
    task automatic prog_page(input logic [7:0] pg);
        wr(8'hFF, pg);
        wr(8'h2F, 8'h40);
        pulse_cmd(8'hC0);
    endtask
endmodule

// ### sfps_pkg.sv
package sfps_pkg;
    localparam logic [7:0] OFS_CMD = 8'h0F;
    localparam logic [7:0] OFS_WAKE = 8'h10;
    localparam logic [7:0] OFS_PTR = 8'h22;
    localparam logic [7:0] OFS_LOCK = 8'h2F;
    localparam logic [7:0] OFS_PWR1 = 8'hE0;
    localparam logic [7:0] OFS_PWR2 = 8'hE1;
    localparam logic [7:0] OFS_PAGE = 8'hFF;
    localparam logic [7:0] PG_MASTER = 8'h00;
    localparam logic [7:0] PG_MONITOR = 8'h01;
    localparam logic [7:0] PG_REFIN = 8'h02;
    localparam logic [7:0] PG_DRIVER = 8'h03;
    localparam logic [7:0] PG_SYNTH1 = 8'h0A;
    localparam logic [7:0] PG_SYNTH4 = 8'h0D;
    localparam int CMD_ESC_BIT = 1;
    localparam logic [4:0] CMD_BURN = 5'h0C;
    localparam int WAKE_MAN_BIT = 7;
    localparam int WAKE_END_BIT = 6;
    localparam logic [7:0] PTR_ALL_SEC = 8'hFF;
    localparam logic [6:0] PWR_ALL = 7'h7F;
    localparam logic [1:0] LOCK_VAL = 2'h1;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_IDX = 4'h0;
    localparam int NUM_PAGES = 8;
    localparam logic [3:0] BURN_CYCLES = 4'h8;
    typedef enum {ST_ACTIVE, ST_PROG_CMD} sfps_state_t;
endpackage

// ### sfps_top.sv
`timescale 1ns/1ps
module sfps_top (
    input wire logic CLK,
    input wire logic RST,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic [7:0] PTR_NV,
    input wire logic [7:0] WAKE_NV,
    output logic [7:0] RDATA,
    output logic PROG_STATE,
    output logic BURN_PULSE,
    output logic [3:0] BURN_PAGE,
    output logic [7:0] PAGES_BURNED,
    output logic [7:0] PTR_APPLIED,
    output logic [13:0] FORCE_PWR,
    output logic MANUAL_WAKE,
    output logic AUTO_BOOT
);
    logic [7:0] page_r;
    logic [7:0] cmd_r;
    logic [7:0] wake_r;
    logic [7:0] ptr_r;
    logic [7:0] lock_r [sfps_pkg::NUM_PAGES];
    logic [7:0] pwr1_r;
    logic [7:0] pwr2_r;
    logic [3:0] pidx;
    logic cmd_wr;
    logic esc_req;
    logic burn_req;
    logic burn_ok;
    logic [7:0] wake_nv_r;
    logic strap_done_r;
    logic [3:0] busy_r;
    sfps_pkg::sfps_state_t state_r;

    // Map page code to internal page index, invalid pages map to 8
    function automatic logic [3:0] page_index(input logic [7:0] pg);
        logic [3:0] idx;
        idx = 4'h8;
        if (pg <= sfps_pkg::PG_DRIVER) begin
            idx = pg[3:0];
        end else if (pg >= sfps_pkg::PG_SYNTH1 && pg <= sfps_pkg::PG_SYNTH4) begin
            idx = 4'(pg - sfps_pkg::PG_SYNTH1) + 4'h4;
        end
        return idx;
    endfunction

    function automatic logic hit(input logic [7:0] ofs, input logic master_only);
        return ADDR == ofs && (!master_only || page_r == sfps_pkg::PG_MASTER);
    endfunction

    assign pidx = page_index(page_r);
    assign cmd_wr = WR_EN && hit(sfps_pkg::OFS_CMD, 1'b0);
    // Zero writes between command values are idle
    assign esc_req = cmd_wr && page_r == sfps_pkg::PG_MASTER
                     && WDATA[sfps_pkg::CMD_ESC_BIT];
    // Burn byte 0xC0 carries code 0xC in bits 7:4 with bit 3 clear
    assign burn_req = cmd_wr && WDATA[7:3] == {sfps_pkg::CMD_BURN[3:0], 1'b0};
    // Burn requires program state, valid page and locked fuse
    assign burn_ok = burn_req && state_r == sfps_pkg::ST_PROG_CMD && pidx[3] == 1'b0
                     && lock_r[pidx[2:0]][7:6] == sfps_pkg::LOCK_VAL
                     && busy_r == sfps_pkg::RST_IDX;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_r <= sfps_pkg::ST_ACTIVE;
        end else if (esc_req) begin
            state_r <= sfps_pkg::ST_PROG_CMD;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            page_r <= sfps_pkg::RST_BYTE;
            cmd_r <= sfps_pkg::RST_BYTE;
            ptr_r <= sfps_pkg::RST_BYTE;
            pwr1_r <= sfps_pkg::RST_BYTE;
            pwr2_r <= sfps_pkg::RST_BYTE;
            wake_r <= sfps_pkg::RST_BYTE;
            strap_done_r <= 1'b0;
        end else begin
            // Nonvolatile copies load after reset release
            if (!strap_done_r) begin
                strap_done_r <= 1'b1;
                ptr_r <= PTR_NV;
                wake_r <= WAKE_NV;
            end
            if (WR_EN) begin
                if (hit(sfps_pkg::OFS_PAGE, 1'b0)) page_r <= WDATA;
                if (cmd_wr) cmd_r <= WDATA;
                if (hit(sfps_pkg::OFS_PTR, 1'b1)) ptr_r <= WDATA;
                if (hit(sfps_pkg::OFS_WAKE, 1'b1)) wake_r <= WDATA;
                if (hit(sfps_pkg::OFS_PWR1, 1'b1)) pwr1_r <= WDATA;
                if (hit(sfps_pkg::OFS_PWR2, 1'b1)) pwr2_r <= WDATA;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < sfps_pkg::NUM_PAGES; i++) lock_r[i] <= sfps_pkg::RST_BYTE;
        end else if (WR_EN && hit(sfps_pkg::OFS_LOCK, 1'b0) && !pidx[3]) begin
            lock_r[pidx[2:0]] <= WDATA;
        end
    end

    // Burn occupies a fixed number of cycles, burn commands during it are dropped
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            busy_r <= sfps_pkg::RST_IDX;
            BURN_PULSE <= 1'b0;
            BURN_PAGE <= sfps_pkg::RST_IDX;
        end else begin
            BURN_PULSE <= burn_ok;
            if (burn_ok) begin
                BURN_PAGE <= pidx;
                busy_r <= sfps_pkg::BURN_CYCLES;
            end else if (busy_r != sfps_pkg::RST_IDX) begin
                busy_r <= busy_r - 4'h1;
            end
        end
    end

    // Previous-session wake strap, captured at release
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wake_nv_r <= sfps_pkg::RST_BYTE;
        end else if (!strap_done_r) begin
            wake_nv_r <= WAKE_NV;
        end
    end

    sfps_fuse_bank u_bank (
        .CLK(CLK),
        .RST(RST),
        .burn(BURN_PULSE),
        .page_idx(BURN_PAGE),
        .ptr_live(PTR_NV),
        .burned(PAGES_BURNED),
        .ptr_applied(PTR_APPLIED)
    );

    always_comb begin
        RDATA = sfps_pkg::RST_BYTE;
        if (RD_EN) begin
            if (hit(sfps_pkg::OFS_PAGE, 1'b0)) RDATA = page_r;
            else if (hit(sfps_pkg::OFS_CMD, 1'b0)) RDATA = cmd_r;
            else if (hit(sfps_pkg::OFS_LOCK, 1'b0) && !pidx[3]) RDATA = lock_r[pidx[2:0]];
            else if (hit(sfps_pkg::OFS_PTR, 1'b1)) RDATA = ptr_r;
            else if (hit(sfps_pkg::OFS_WAKE, 1'b1)) RDATA = wake_r;
            else if (hit(sfps_pkg::OFS_PWR1, 1'b1)) RDATA = pwr1_r;
            else if (hit(sfps_pkg::OFS_PWR2, 1'b1)) RDATA = pwr2_r;
        end
    end

    assign PROG_STATE = state_r == sfps_pkg::ST_PROG_CMD;
    assign FORCE_PWR = {pwr2_r[6:0] & sfps_pkg::PWR_ALL, pwr1_r[6:0] & sfps_pkg::PWR_ALL};
    // Manual wake needs bit 7 set and bit 6 clear
    assign MANUAL_WAKE = wake_r[sfps_pkg::WAKE_MAN_BIT]
                         && !wake_r[sfps_pkg::WAKE_END_BIT];
    // Autonomous boot once released unless the stored wake byte has bit 7 set and bit 6 clear
    assign AUTO_BOOT = strap_done_r && (!wake_nv_r[sfps_pkg::WAKE_MAN_BIT]
                       || wake_nv_r[sfps_pkg::WAKE_END_BIT]);

    property p_no_burn_active;
        @(posedge CLK) disable iff (RST)
        state_r == sfps_pkg::ST_ACTIVE |=> !BURN_PULSE;
    endproperty
    a_no_burn_active: assert property (p_no_burn_active) else $error("burn in active");

    property p_esc;
        @(posedge CLK) disable iff (RST) esc_req |=> PROG_STATE;
    endproperty
    a_esc: assert property (p_esc) else $error("escape missed");

    property p_burn_once;
        @(posedge CLK) disable iff (RST) BURN_PULSE |=> !BURN_PULSE;
    endproperty
    a_burn_once: assert property (p_burn_once) else $error("double burn");

    property p_burn_lock;
        @(posedge CLK) disable iff (RST)
        BURN_PULSE |-> lock_r[BURN_PAGE[2:0]][7:6] == sfps_pkg::LOCK_VAL;
    endproperty
    a_burn_lock: assert property (p_burn_lock) else $error("burn unlocked");

    // Refusals of a burn request on an unlocked or invalid page, in either state
    property p_lock_refuse;
        @(posedge CLK) disable iff (RST)
        burn_req && !pidx[3] && lock_r[pidx[2:0]][7:6] != sfps_pkg::LOCK_VAL |=> !BURN_PULSE;
    endproperty
    a_lock_refuse: assert property (p_lock_refuse) else $error("unlocked page burned");

    property p_bad_page;
        @(posedge CLK) disable iff (RST) burn_req && pidx[3] |=> !BURN_PULSE;
    endproperty
    a_bad_page: assert property (p_bad_page) else $error("invalid page burned");

    property p_burned;
        @(posedge CLK) disable iff (RST) BURN_PULSE |=> PAGES_BURNED[BURN_PAGE[2:0]];
    endproperty
    a_burned: assert property (p_burned) else $error("page not marked");

    property p_ptr_frozen;
        @(posedge CLK) disable iff (RST) strap_done_r |=> $stable(PTR_APPLIED);
    endproperty
    a_ptr_frozen: assert property (p_ptr_frozen) else $error("pointer moved");

    property p_manual;
        @(posedge CLK) disable iff (RST)
        wake_r[7:6] == 2'h2 |-> MANUAL_WAKE;
    endproperty
    a_manual: assert property (p_manual) else $error("manual lost");

    property p_page_synth;
        @(posedge CLK) disable iff (RST)
        page_r == sfps_pkg::PG_SYNTH1 |-> pidx == 4'h4;
    endproperty
    a_page_synth: assert property (p_page_synth) else $error("page map");

    c_esc: cover property (@(posedge CLK) disable iff (RST) esc_req);
    c_burn: cover property (@(posedge CLK) disable iff (RST) BURN_PULSE);
    c_drop: cover property (@(posedge CLK) disable iff (RST) burn_req && !burn_ok);
    c_synth4: cover property (@(posedge CLK) disable iff (RST) BURN_PULSE && BURN_PAGE == 4'h7);
endmodule

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
    logic CLK, RST, WR_EN, RD_EN, PROG_STATE, BURN_PULSE, MANUAL_WAKE, AUTO_BOOT;
    logic [7:0] ADDR, WDATA, PTR_NV, WAKE_NV, RDATA, PAGES_BURNED, PTR_APPLIED;
    logic [3:0] BURN_PAGE, last_pg;
    logic [13:0] FORCE_PWR;
    int fails = 0, n_tests = 0, n_burn = 0, nb;
    logic [7:0] row_pg [7] = '{8'h02, 8'h01, 8'h03, 8'h0A, 8'h0B, 8'h0C, 8'h0D};
    logic [3:0] row_ix [7] = '{4'h2, 4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
    sfps_top dut (.CLK(CLK), .RST(RST), .WR_EN(WR_EN), .RD_EN(RD_EN), .ADDR(ADDR),
        .WDATA(WDATA), .PTR_NV(PTR_NV), .WAKE_NV(WAKE_NV), .RDATA(RDATA),
        .PROG_STATE(PROG_STATE), .BURN_PULSE(BURN_PULSE), .BURN_PAGE(BURN_PAGE),
        .PAGES_BURNED(PAGES_BURNED), .PTR_APPLIED(PTR_APPLIED), .FORCE_PWR(FORCE_PWR),
        .MANUAL_WAKE(MANUAL_WAKE), .AUTO_BOOT(AUTO_BOOT));
    sfps_host_model host (.CLK(CLK), .RDATA(RDATA), .WR_EN(WR_EN), .RD_EN(RD_EN),
        .ADDR(ADDR), .WDATA(WDATA));
    always #12.5 CLK = ~CLK;
    always @(posedge CLK) begin
        if (BURN_PULSE === 1'b1) begin
            n_burn++;
            last_pg = BURN_PAGE;
        end
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task burn_chk(input logic [7:0] pg, input int exp_n);
        nb = n_burn;
        host.prog_page(pg);
        chk(16'(n_burn - nb), 16'(exp_n));
    endtask
    task do_rst(input logic [7:0] p, input logic [7:0] w);
        @(negedge CLK);
        RST = 1'b1;
        PTR_NV = p;
        WAKE_NV = w;
        repeat (3) @(negedge CLK);
        RST = 1'b0;
        repeat (2) @(negedge CLK);
    endtask
    task wrap_up;
        $display("tests %0d failures %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge CLK);
        fails++;
        wrap_up;
    end
    initial begin
        CLK = 1'b0;
        RST = 1'b1;
        PTR_NV = 8'h00;
        WAKE_NV = 8'h00;
        repeat (10) @(negedge CLK);
        chk({PROG_STATE, BURN_PULSE, PAGES_BURNED, FORCE_PWR[5:0]}, 16'h0000);
        RST = 1'b0;
        repeat (2) @(negedge CLK);
        burn_chk(8'h00, 0);
        chk(PROG_STATE, 16'h0000);
        host.pulse_cmd(8'h02);
        chk(PROG_STATE, 16'h0001);
        host.wr(8'h22, 8'hFF);
        host.rd(8'h22);
        chk(host.rd_val, 16'h00FF);
        chk(PTR_APPLIED, 16'h0000);
        host.set_bit(8'h10, 7);
        host.rd(8'h10);
        chk(host.rd_val, 16'h0080);
        chk(MANUAL_WAKE, 16'h0001);
        burn_chk(8'h00, 1);
        chk({last_pg, PAGES_BURNED}, 16'h0001);
        do_rst(8'hFF, 8'h80);
        // Stored bytes moving mid-run must not reach the applied copies
        PTR_NV = 8'h3C;
        WAKE_NV = 8'hC0;
        repeat (2) @(negedge CLK);
        chk({PTR_APPLIED, MANUAL_WAKE, AUTO_BOOT}, 16'h03FE);
        host.wr(8'hFF, 8'h02);
        host.pulse_cmd(8'h02);
        chk(PROG_STATE, 16'h0000);
        host.wr(8'hFF, 8'h00);
        host.pulse_cmd(8'h02);
        host.wr(8'hE0, 8'h7F);
        host.wr(8'hE1, 8'h7F);
        chk(FORCE_PWR, 16'h3FFF);
        for (int i = 0; i < 7; i++) begin
            burn_chk(row_pg[i], 1);
            chk({last_pg, 7'h00, PAGES_BURNED[row_ix[i]]}, {row_ix[i], 8'h01});
        end
        host.rd(8'h22);
        chk(host.rd_val, 16'h0000);
        host.wr(8'h2F, 8'h80);
        nb = n_burn;
        host.pulse_cmd(8'hC0);
        chk(16'(n_burn - nb), 16'h0000);
        burn_chk(8'h05, 0);
        host.wr(8'hFF, 8'h00);
        host.pulse_cmd(8'h02);
        host.set_bit(8'h10, 6);
        chk(MANUAL_WAKE, 16'h0000);
        burn_chk(8'h00, 1);
        nb = n_burn;
        host.pulse_cmd(8'hC0);
        chk(16'(n_burn - nb), 16'h0000);
        do_rst(8'hFF, 8'hC0);
        chk({PTR_APPLIED, AUTO_BOOT}, 16'h01FF);
        wrap_up;
    end
endmodule
